// ### pin_ctl.sv
// Live status flags and first multipurpose pin function control
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module pin_ctl #(
	parameter int PULSE_CYCLES = pin_ctl_pkg::PULSE_CYC,
	parameter int HOOK_CYCLES  = pin_ctl_pkg::HOOK_CYC
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Register port
	input  wire pin_ctl_pkg::reg_req_t req,
	output logic [7:0]                 rdata,
	// Status sources
	input  wire pin_ctl_pkg::live_in_t live_in,
	// Clock sources and word clock direction
	input  wire pin_ctl_pkg::clk_src_t clk_src,
	input  wire logic                  wclk_drive,
	// Multipurpose pin
	input  wire logic                  pin_in,
	output logic                       pin_out,
	output logic                       pin_oe,
	output logic                       wclk_from_pin
);
	import pin_ctl_pkg::*;

	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
	localparam logic [CNT_W-1:0] HOOK_LAST  = CNT_W'(HOOK_CYCLES - 1);

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0]       rdata;
		pin_func_t        func;
		logic             clk_sel;
		logic             cont;
		logic             out_val;
		logic [7:0]       sticky;
		logic             btn_latch;
		logic             hs_prev;
		logic             lvl_prev;
		logic             btn_prev;
		irq_st_t          irq_st;
		logic             repeat_on;
		logic [CNT_W-1:0] irq_cnt;
		logic [CNT_W-1:0] hook_cnt;
		logic             hook_on;
		logic             pin_out;
		logic             pin_oe;
		logic             wclk_in;
	} pin_st_t;

	pin_st_t s_q;
	pin_st_t s_d;

	logic       div_clk;
	logic       mux_src;
	logic [1:0] div_ratio;

	// ==========================================================
	// Divided clock
	assign mux_src   = s_q.clk_sel ? clk_src.div_mux : clk_src.pll;
	assign div_ratio = 2'(s_q.func - FN_DIV1);

	clk_div_out u_div (
		.core_clk (core_clk),
		.rst      (rst),
		.src      (mux_src),
		.ratio    (div_ratio),
		.div_q    (div_clk)
	);

	// ==========================================================
	// Event decode
	logic       wr_ctrl;
	logic       rd_live;
	logic       rd_ctrl;
	logic       rd_sticky;
	logic       rd_btn;
	logic       sc_any;
	logic       agc_any;
	logic       hs_evt;
	logic       btn_rise;
	logic       lvl;
	logic       trig;
	logic       irq_mode;
	logic [7:0] sticky_set;

	always_comb begin
		wr_ctrl   = req.wr && (req.addr == CTRL_ADDR);
		rd_live   = req.rd && (req.addr == LIVE_ADDR);
		rd_ctrl   = req.rd && (req.addr == CTRL_ADDR);
		rd_sticky = req.rd && (req.addr == STICKY_ADDR);
		rd_btn    = req.rd && (req.addr == BTN_CLEAR_ADDR);
		sc_any    = |live_in.short_det;
		agc_any   = live_in.agc_left | live_in.agc_right;
		hs_evt    = live_in.headset ^ s_q.hs_prev;
		btn_rise  = live_in.button && !s_q.btn_prev;
		sticky_set = {live_in.short_det, btn_rise, hs_evt,
			live_in.agc_left, live_in.agc_right};
		// Level sources fire on their rising edge only
		lvl  = 1'b0;
		trig = 1'b0;
		irq_mode = 1'b1;
		case (s_q.func)
			FN_SC_IRQ:  lvl = sc_any;
			FN_AGC_IRQ: lvl = agc_any;
			FN_HS_IRQ:  trig = hs_evt;
			FN_HS_BTN:  begin
				lvl  = live_in.button;
				trig = hs_evt;
			end
			FN_ALL_IRQ: begin
				lvl  = live_in.button | sc_any | agc_any;
				trig = hs_evt;
			end
			default:    irq_mode = 1'b0;
		endcase
		trig = trig | (lvl && !s_q.lvl_prev);
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;
		s_d.hs_prev  = live_in.headset;
		s_d.btn_prev = live_in.button;
		s_d.lvl_prev = lvl;

		// Register writes
		if (wr_ctrl) begin
			s_d.func    = pin_func_t'(req.wdata[FUNC_MSB:FUNC_LSB]);
			s_d.clk_sel = req.wdata[CLK_SEL_BIT];
			s_d.cont    = req.wdata[CONT_BIT];
			s_d.out_val = req.wdata[GP_OUT_BIT];
		end

		// Read data stands for one cycle only
		s_d.rdata = 8'h00;
		if (rd_live) begin
			s_d.rdata = {live_in.short_det, s_q.btn_latch,
				live_in.headset,
				live_in.agc_left, live_in.agc_right};
		end else if (rd_ctrl) begin
			s_d.rdata = {s_q.func, s_q.clk_sel, s_q.cont,
				(s_q.func == FN_GP_IN) && pin_in,
				s_q.out_val};
		end else if (rd_sticky) begin
			s_d.rdata = s_q.sticky;
		end

		// Flags: a set in the clearing cycle wins
		if (rd_btn) begin
			s_d.btn_latch = 1'b0;
		end
		if (btn_rise) begin
			s_d.btn_latch = 1'b1;
		end
		s_d.sticky = (rd_sticky ? 8'h00 : s_q.sticky) | sticky_set;

		// Interrupt pulse sequencer
		if (rd_sticky) begin
			s_d.repeat_on = 1'b0;
		end
		case (s_q.irq_st)
			IRQ_IDLE: begin
				s_d.irq_cnt = '0;
			end
			IRQ_HIGH: begin
				s_d.irq_cnt = s_q.irq_cnt + CNT_W'(1);
				if (s_q.irq_cnt == PULSE_LAST) begin
					s_d.irq_cnt = '0;
					s_d.irq_st = s_d.repeat_on ? IRQ_GAP : IRQ_IDLE;
				end
			end
			IRQ_GAP: begin
				s_d.irq_cnt = s_q.irq_cnt + CNT_W'(1);
				if (!s_d.repeat_on) begin
					s_d.irq_st  = IRQ_IDLE;
					s_d.irq_cnt = '0;
				end else if (s_q.irq_cnt == PULSE_LAST) begin
					s_d.irq_st  = IRQ_HIGH;
					s_d.irq_cnt = '0;
				end
			end
			default: begin
				s_d.irq_st  = IRQ_IDLE;
				s_d.irq_cnt = '0;
			end
		endcase
		// A new trigger restarts the pulse, even over a read
		if (trig && irq_mode) begin
			s_d.irq_st    = IRQ_HIGH;
			s_d.irq_cnt   = '0;
			s_d.repeat_on = s_q.cont;
		end
		if (!irq_mode) begin
			s_d.irq_st    = IRQ_IDLE;
			s_d.irq_cnt   = '0;
			s_d.repeat_on = 1'b0;
		end

		// Button interrupt: delay after press, held until release
		if (live_in.button) begin
			if (s_q.hook_cnt == HOOK_LAST) begin
				s_d.hook_on = 1'b1;
			end else begin
				s_d.hook_cnt = s_q.hook_cnt + CNT_W'(1);
			end
		end else begin
			s_d.hook_cnt = '0;
			s_d.hook_on  = 1'b0;
		end

		// Pin multiplexer
		s_d.pin_out = 1'b0;
		s_d.pin_oe  = 1'b1;
		s_d.wclk_in = 1'b0;
		case (s_q.func)
			FN_OFF:     s_d.pin_oe = 1'b0;
			FN_ADC_WCK: s_d.pin_out = clk_src.adc_wclk;
			FN_DIV1,
			FN_DIV2,
			FN_DIV4,
			FN_DIV8:    s_d.pin_out = div_clk;
			FN_SC_IRQ,
			FN_AGC_IRQ,
			FN_HS_IRQ,
			FN_HS_BTN,
			FN_ALL_IRQ: s_d.pin_out = (s_q.irq_st == IRQ_HIGH);
			FN_GP_IN:   s_d.pin_oe = 1'b0;
			FN_GP_OUT:  s_d.pin_out = s_q.out_val;
			FN_DMIC:    s_d.pin_out = clk_src.dmic;
			FN_WCLK:    begin
				s_d.pin_oe  = wclk_drive;
				s_d.pin_out = wclk_drive && clk_src.wclk;
				s_d.wclk_in = !wclk_drive && pin_in;
			end
			FN_HOOK:    s_d.pin_out = s_q.hook_on;
			default:    s_d.pin_oe = 1'b0;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q         <= '0;
			s_q.func    <= pin_func_t'(FUNC_RESET);
			s_q.sticky  <= STICKY_RESET;
			s_q.irq_st  <= IRQ_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata         = s_q.rdata;
	assign pin_out       = s_q.pin_out;
	assign pin_oe        = s_q.pin_oe;
	assign wclk_from_pin = s_q.wclk_in;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_live_shorts: assert property (
		rd_live |=> rdata[7:4] == $past(live_in.short_det))
		else $error("live short bits wrong");

	a_live_presence: assert property (
		rd_live |=> rdata[2] == $past(live_in.headset)
			&& rdata[1] == $past(live_in.agc_left)
			&& rdata[0] == $past(live_in.agc_right))
		else $error("live presence or noise bits wrong");

	a_button_sticky: assert property (
		(btn_rise || (s_q.btn_latch && !rd_btn)) |=> s_q.btn_latch)
		else $error("button bit lost before clearing read");

	a_button_clear: assert property (
		(rd_btn && !btn_rise) |=> !s_q.btn_latch)
		else $error("button bit not cleared by read");

	a_button_shown: assert property (
		rd_live |=> rdata[3] == $past(s_q.btn_latch))
		else $error("button bit not shown on live read");

	a_pin_disabled: assert property (
		s_q.func == FN_OFF |=> !pin_oe)
		else $error("pin driven while disabled");

	a_gp_output: assert property (
		(s_q.func == FN_GP_OUT && $stable(s_q.func))
			|=> pin_oe && pin_out == $past(s_q.out_val))
		else $error("general output level wrong");

	a_gp_input: assert property (
		(rd_ctrl && s_q.func == FN_GP_IN)
			|=> !pin_oe && rdata[1] == $past(pin_in))
		else $error("general input level not reported");

	a_pulse_start: assert property (
		(trig && irq_mode) |=> s_q.irq_st == IRQ_HIGH
			&& s_q.irq_cnt == '0)
		else $error("interrupt pulse did not start");

	a_single_end: assert property (
		(s_q.irq_st == IRQ_HIGH && s_q.irq_cnt == PULSE_LAST
			&& !s_q.repeat_on && !trig)
			|=> s_q.irq_st == IRQ_IDLE)
		else $error("single pulse did not end on time");

	a_repeat_stop: assert property (
		(rd_sticky && !(trig && irq_mode)) |=> !s_q.repeat_on)
		else $error("repeating pulses not stopped by read");

	a_sticky_hold: assert property (
		(hs_evt && !rd_sticky) |=> s_q.sticky[2])
		else $error("headset change not latched");

	a_hook_quiet: assert property (
		(s_q.func == FN_HOOK && !s_q.hook_on) |=> !pin_out)
		else $error("button interrupt raised too early");

endmodule

`default_nettype wire

// ### pin_ctl_pkg.sv
// Package: register map, field layout, function codes and timing of the pin block
package pin_ctl_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] BTN_CLEAR_ADDR = 8'h0e;
	localparam logic [7:0] STICKY_ADDR    = 8'h60;
	localparam logic [7:0] LIVE_ADDR      = 8'h61;
	localparam logic [7:0] CTRL_ADDR      = 8'h62;

	// ==========================================================
	// Control register fields and reset values
	localparam int FUNC_MSB    = 7;
	localparam int FUNC_LSB    = 4;
	localparam int CLK_SEL_BIT = 3;
	localparam int CONT_BIT    = 2;
	localparam int GP_IN_BIT   = 1;
	localparam int GP_OUT_BIT  = 0;
	localparam logic [3:0] FUNC_RESET   = 4'h0;
	localparam logic [7:0] STICKY_RESET = 8'h00;

	// ==========================================================
	// Pin function codes
	typedef enum logic [3:0] {
		FN_OFF     = 4'h0,
		FN_ADC_WCK = 4'h1,
		FN_DIV1    = 4'h2,
		FN_DIV2    = 4'h3,
		FN_DIV4    = 4'h4,
		FN_DIV8    = 4'h5,
		FN_SC_IRQ  = 4'h6,
		FN_AGC_IRQ = 4'h7,
		FN_GP_IN   = 4'h8,
		FN_GP_OUT  = 4'h9,
		FN_DMIC    = 4'ha,
		FN_WCLK    = 4'hb,
		FN_HOOK    = 4'hc,
		FN_HS_IRQ  = 4'hd,
		FN_HS_BTN  = 4'he,
		FN_ALL_IRQ = 4'hf
	} pin_func_t;

	// Interrupt pulse sequencer, Gray along idle -> high -> gap
	typedef enum logic [1:0] {
		IRQ_IDLE = 2'b00,
		IRQ_HIGH = 2'b01,
		IRQ_GAP  = 2'b11
	} irq_st_t;

	// ==========================================================
	// Timing
	localparam int CLK_NS     = 40;
	localparam int PULSE_US   = 2000;
	localparam int HOOK_US    = 500;
	localparam int PULSE_CYC  = PULSE_US * 1000 / CLK_NS;
	localparam int HOOK_CYC   = HOOK_US * 1000 / CLK_NS;
	localparam int CNT_W      = 17;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [3:0] short_det;
		logic       button;
		logic       headset;
		logic       agc_left;
		logic       agc_right;
	} live_in_t;

	typedef struct packed {
		logic pll;
		logic div_mux;
		logic adc_wclk;
		logic dmic;
		logic wclk;
	} clk_src_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage

// ### clk_div_out.sv
// Divider that produces the divided clock-mux output for the pin
`timescale 1ns/1ns
`default_nettype none

module clk_div_out (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Source level and ratio select: 0 /1, 1 /2, 2 /4, 3 /8
	input  wire logic       src,
	input  wire logic [1:0] ratio,
	// Divided level
	output logic            div_q
);

	typedef struct packed {
		logic       src_prev;
		logic [2:0] cnt;
		logic       div;
	} div_st_t;

	div_st_t s_q;
	div_st_t s_d;

	assign div_q = s_q.div;

	always_comb begin
		s_d = s_q;
		s_d.src_prev = src;
		if (src && !s_q.src_prev) begin
			s_d.cnt = s_q.cnt + 3'h1;
		end
		case (ratio)
			2'h0:    s_d.div = src;
			2'h1:    s_d.div = s_d.cnt[0];
			2'h2:    s_d.div = s_d.cnt[1];
			default: s_d.div = s_d.cnt[2];
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

`default_nettype wire

// ### pin_host.sv
// Host-side model of the first multipurpose pin
`timescale 1ns/1ns
`default_nettype none

module pin_host (
	// Clock
	input  wire logic core_clk,
	// Device side of the pin
	input  wire logic pin_out,
	input  wire logic pin_oe,
	// Level the host puts on the pin while the device lets go of it
	input  wire logic drive_lvl,
	output logic      pin_in,
	output var int    rises
);
	logic last_q;
	int   cnt = 0;

	// =====================================
	// Resolved wire level
	// The device wins while it drives, so the host never fights it
	assign pin_in = pin_oe ? pin_out : drive_lvl;
	assign rises  = cnt;

	// Edges the host would take as clocks or interrupts
	always @(posedge core_clk) begin
		last_q <= pin_in;
		if (pin_in && !last_q)
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the live flags and pin function block
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import pin_ctl_pkg::*;
	localparam int PULSE = 8;
	localparam int HOOK  = 4;
	logic     core_clk = 0;
	logic     rst = 1;
	reg_req_t req = '0;
	logic [7:0] rdata;
	live_in_t live_in = '0;
	clk_src_t clk_src = '0;
	logic     wclk_drive = 1;
	logic     drive_lvl = 0;
	logic     pin_in, pin_out, pin_oe, wclk_from_pin;
	logic [7:0] pins;
	int       rises, fails = 0, comparisons = 0, cycles = 0, i, n, r0;
	logic [7:0] ctl_tab[5] = '{8'h10, 8'ha0, 8'hb0, 8'h20, 8'h28};
	logic [4:0] src_tab[5] = '{5'h04, 5'h02, 5'h01, 5'h10, 5'h08};
	logic [3:0] irq_code[6] = '{4'h6, 4'h7, 4'hd, 4'he, 4'hf, 4'h6};
	logic [7:0] irq_trig[6] = '{8'h10, 8'h01, 8'h04, 8'h08, 8'h02, 8'h02};
	int         irq_len[6]  = '{PULSE, PULSE, PULSE, PULSE, PULSE, 0};

	pin_ctl #(.PULSE_CYCLES(PULSE), .HOOK_CYCLES(HOOK)) pin_ctl_inst (
		.core_clk(core_clk), .rst(rst), .req(req), .rdata(rdata),
		.live_in(live_in), .clk_src(clk_src), .wclk_drive(wclk_drive),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.wclk_from_pin(wclk_from_pin));
	assign pins = {6'h0, pin_oe, pin_out};
	pin_host pin_host_inst (.core_clk(core_clk), .pin_out(pin_out),
		.pin_oe(pin_oe), .drive_lvl(drive_lvl), .pin_in(pin_in),
		.rises(rises));

	// =====================================
	// Clock and hang guard
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end

	// =====================================
	// Access tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk) req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) req.rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// Waits a bounded time for a pulse, then measures its length
	task automatic pulse(output int len);
		int w;
		len = 0;
		for (w = 0; w < 20 && pin_out !== 1'b1; w++)
			tick(1);
		while (pin_out === 1'b1 && len < 100) begin
			tick(1);
			len++;
		end
	endtask
	task automatic wrap_up();
		$display("Counts: %0d compared, %0d failed", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// =====================================
	// Tests
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		tick(1);
		chk({7'h0, pin_oe}, 8'h00);
		rd(CTRL_ADDR, 8'h00);
		@(posedge core_clk) live_in <= 8'ha5;
		rd(LIVE_ADDR, 8'ha5);
		@(posedge core_clk) live_in <= 8'h5a;
		rd(LIVE_ADDR, 8'h5a);
		@(posedge core_clk) live_in <= 8'h50;
		rd(LIVE_ADDR, 8'h58);
		rd(BTN_CLEAR_ADDR, 8'h00);
		rd(LIVE_ADDR, 8'h50);
		@(posedge core_clk) live_in <= '0;
		rd(STICKY_ADDR, 8'hff);
		rd(8'h55, 8'h00);
		wr(LIVE_ADDR, 8'hff);
		rd(CTRL_ADDR, 8'h00);
		$display("test flags done");

		wr(CTRL_ADDR, 8'h91);
		tick(2);
		chk({6'h0, pin_oe, pin_out}, 8'h03);
		wr(CTRL_ADDR, 8'h90);
		tick(2);
		chk({6'h0, pin_oe, pin_out}, 8'h02);
		wr(CTRL_ADDR, 8'h82);
		tick(3);
		rd(CTRL_ADDR, 8'h80);
		@(posedge core_clk) drive_lvl <= 1'b1;
		rd(CTRL_ADDR, 8'h82);
		chk({7'h0, pin_oe}, 8'h00);
		$display("test general pin done");

		for (i = 0; i < 5; i++) begin
			wr(CTRL_ADDR, ctl_tab[i]);
			@(posedge core_clk) clk_src <= src_tab[i];
			tick(4);
			chk(pins, 8'h03);
			@(posedge core_clk) clk_src <= ~src_tab[i];
			tick(4);
			chk(pins, 8'h02);
		end
		wr(CTRL_ADDR, 8'hb0);
		@(posedge core_clk) wclk_drive <= 1'b0;
		tick(3);
		chk({6'h0, pin_oe, wclk_from_pin}, 8'h01);
		@(posedge core_clk) wclk_drive <= 1'b1;
		for (i = 1; i < 4; i++) begin
			wr(CTRL_ADDR, {4'h2 + 4'(i), 4'h0});
			tick(16);
			r0 = rises;
			repeat (64) @(posedge core_clk) clk_src.pll <= ~clk_src.pll;
			n = (rises - r0) - (32 >> i);
			chk({7'h0, n >= -1 && n <= 1}, 8'h01);
		end
		$display("test clock outputs done");

		wr(CTRL_ADDR, 8'h64);
		r0 = rises;
		@(posedge core_clk) live_in <= 8'h10;
		tick(60);
		chk({7'h0, (rises - r0) >= 3}, 8'h01);
		rd(STICKY_ADDR, 8'h10);
		tick(2 * PULSE);
		r0 = rises;
		tick(40);
		chk(8'(rises - r0), 8'h00);
		@(posedge core_clk) live_in <= '0;
		$display("test repeating pulses done");

		for (i = 0; i < 6; i++) begin
			wr(CTRL_ADDR, {irq_code[i], 4'h0});
			tick(3);
			@(posedge core_clk) live_in <= irq_trig[i];
			pulse(n);
			chk(8'(n), 8'(irq_len[i]));
			tick(30);
			chk({7'h0, pin_out}, 8'h00);
			@(posedge core_clk) live_in <= '0;
			tick(30);
		end
		$display("test interrupt pulses done");

		wr(CTRL_ADDR, 8'hc0);
		@(posedge core_clk) live_in <= 8'h08;
		tick(2);
		chk({7'h0, pin_out}, 8'h00);
		tick(HOOK + 3);
		chk({7'h0, pin_out}, 8'h01);
		tick(20);
		chk({7'h0, pin_out}, 8'h01);
		@(posedge core_clk) live_in <= '0;
		tick(4);
		chk({7'h0, pin_out}, 8'h00);
		$display("test hook switch done");
		wrap_up();
	end
endmodule
`default_nettype wire
